//--- sct_ctl_second.sv
`include "sct_params.svh"

module sct_ctl_second #(
  parameter bit HAS_FIFO = 1'b1
) (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  // register port
  input  wire logic                   i_reg_sel,
  input  wire logic                   i_reg_wr,
  input  wire logic [`SCT_ADDR_W-1:0] i_reg_addr,
  input  wire logic [3:0]             i_reg_be,
  input  wire logic [31:0]            i_reg_wdata,
  output logic      [31:0]            o_reg_rdata,
  output logic                        o_reg_ack,
  // unit state from the first control register and engine
  input  wire logic                   i_unit_enable,
  input  wire logic                   i_master_mode,
  input  wire logic                   i_data_wr_half,
  // status flags
  input  wire logic                   i_tx_empty_flag,
  input  wire logic [2:0]             i_rx_fifo_bytes,
  input  wire logic                   i_crc_mismatch_flag,
  input  wire logic                   i_config_fault_flag,
  input  wire logic                   i_format_error_flag,
  input  wire logic                   i_rx_overrun_flag,
  input  wire logic                   i_tx_underrun_flag,
  // to interrupt and dma controllers
  output logic                        o_irq,
  output logic                        o_tx_dma_req,
  output logic                        o_rx_dma_req,
  // to the shift engine
  output logic                        o_rx_not_empty_flag,
  output logic      [1:0]             o_rx_fifo_level,
  output logic                        o_tx_dma_odd_count,
  output logic                        o_rx_dma_odd_count,
  output logic      [4:0]             o_frame_bits,
  output logic                        o_fifo_byte_access,
  output logic                        o_packed_mode,
  // link side
  input  wire logic                   i_link_clk,
  input  wire logic                   i_link_frame_start,
  input  wire logic                   i_link_frame_end,
  output logic                        o_slave_select_out,
  output logic                        o_slave_select_oe_n
);

  sct_pkg::sct_main_t     st_ff;
  sct_pkg::sct_main_t     nxt_st;
  logic [31:0]            lane_mask;
  logic [31:0]            rw_mask;
  logic [31:0]            rst_val;
  logic [`SCT_CFG_W-1:0]  cfg_ref;
  logic [`SCT_CFG_W-1:0]  cfg_link;
  logic                   err_any;

  assign rw_mask = HAS_FIFO ? `SCT_MASK_FIFO : `SCT_MASK_BASIC;
  assign rst_val = HAS_FIFO ? `SCT_RST_FIFO : `SCT_RST_BASIC;

  // each byte enable opens its own lane, so every access width behaves alike
  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign lane_mask[8*g +: 8] = {8{i_reg_be[g]}};
  end

  assign err_any = i_crc_mismatch_flag | i_config_fault_flag | i_format_error_flag |
                   i_rx_overrun_flag | i_tx_underrun_flag;

  always_comb
  begin
    logic        take;
    logic        hit;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [3:0]  dz;
    logic [3:0]  dz_eff;
    logic        rxne;
    take   = 1'b0;
    hit    = 1'b0;
    wmask  = '0;
    merged = '0;
    dz     = '0;
    dz_eff = '0;
    rxne   = 1'b0;
    nxt_st = st_ff;

    take = i_reg_sel & ~st_ff.ack;
    hit  = (i_reg_addr == `SCT_CTL1_OFF);
    nxt_st.ack = take;

    if (take && i_reg_wr && hit)
    begin
      wmask = lane_mask & rw_mask;
      if (i_unit_enable)
      begin
        wmask = wmask & ~`SCT_MASK_ODD;
      end
      merged = (st_ff.ctl & ~wmask) | (i_reg_wdata & wmask);
      // storing the forced code keeps readback and engine in agreement
      if (HAS_FIFO && (merged[`SCT_DZ_HI:`SCT_DZ_LO] < `SCT_DZ_MIN))
      begin
        merged[`SCT_DZ_HI:`SCT_DZ_LO] = `SCT_DZ_FORCE;
      end
      nxt_st.ctl = merged;
    end

    if (take && !i_reg_wr)
    begin
      nxt_st.rdata = hit ? st_ff.ctl : '0;
    end

    // frame length; the basic instance has no size field and stays at 8 bits
    dz     = st_ff.ctl[`SCT_DZ_HI:`SCT_DZ_LO];
    dz_eff = HAS_FIFO ? dz : `SCT_DZ_FORCE;
    nxt_st.frame_bits = {1'b0, dz_eff} + 5'h01;

    nxt_st.byte_access = HAS_FIFO & st_ff.ctl[`SCT_B_BYTE];
    nxt_st.packed_mode = HAS_FIFO & (dz_eff <= `SCT_DZ_BYTE_MAX) &
                         i_data_wr_half;

    // without a fifo the single buffer counts as one byte of level
    if (!HAS_FIFO || st_ff.ctl[`SCT_B_BYTE])
    begin
      rxne = (i_rx_fifo_bytes >= `SCT_LVL_ONE);
    end
    else
    begin
      rxne = (i_rx_fifo_bytes >= `SCT_LVL_TWO);
    end
    nxt_st.rxne = rxne;

    // anything above half counts as full
    if (i_rx_fifo_bytes == 3'h0)
    begin
      nxt_st.lvl_code = `SCT_CODE_EMPTY;
    end
    else if (i_rx_fifo_bytes == `SCT_LVL_ONE)
    begin
      nxt_st.lvl_code = `SCT_CODE_QUARTER;
    end
    else if (i_rx_fifo_bytes == `SCT_LVL_TWO)
    begin
      nxt_st.lvl_code = `SCT_CODE_HALF;
    end
    else
    begin
      nxt_st.lvl_code = `SCT_CODE_FULL;
    end

    nxt_st.irq = (st_ff.ctl[`SCT_B_TXIE] & i_tx_empty_flag) |
                 (st_ff.ctl[`SCT_B_RXIE] & rxne) |
                 (st_ff.ctl[`SCT_B_ERROR_IRQ_EN] & err_any);

    nxt_st.tx_req = st_ff.ctl[`SCT_B_TXDMA] & i_tx_empty_flag &
                    i_unit_enable;
    nxt_st.rx_req = st_ff.ctl[`SCT_B_RXDMA] & rxne & i_unit_enable;

    nxt_st.tx_odd_eff = HAS_FIFO & st_ff.ctl[`SCT_B_TXODD] &
                        st_ff.ctl[`SCT_B_TXDMA] & nxt_st.packed_mode;
    nxt_st.rx_odd_eff = HAS_FIFO & st_ff.ctl[`SCT_B_RXODD] &
                        st_ff.ctl[`SCT_B_RXDMA] & nxt_st.packed_mode;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff            <= '0;
      st_ff.ctl        <= HAS_FIFO ? `SCT_RST_FIFO : `SCT_RST_BASIC;
      st_ff.frame_bits <= 5'h08;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // link configuration, carried by handshake into the link clock
  always_comb
  begin
    cfg_ref                 = '0;
    cfg_ref[`SCT_CFG_ALT]   = st_ff.ctl[`SCT_B_ALT];
    cfg_ref[`SCT_CFG_PULSE] = st_ff.ctl[`SCT_B_PULSE];
    cfg_ref[`SCT_CFG_DRV]   = st_ff.ctl[`SCT_B_DRV];
    cfg_ref[`SCT_CFG_MST]   = i_master_mode;
    cfg_ref[`SCT_CFG_EN]    = i_unit_enable;
  end

  sct_cfg_cdc u_cfg_cdc (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_cfg      (cfg_ref),
    .i_link_clk (i_link_clk),
    .o_cfg      (cfg_link)
  );

  sct_sel_gen u_sel_gen (
    .i_link_clk    (i_link_clk),
    .i_rst_n       (i_rst_n),
    .i_cfg         (cfg_link),
    .i_frame_start (i_link_frame_start),
    .i_frame_end   (i_link_frame_end),
    .o_ss_out      (o_slave_select_out),
    .o_ss_oe_n     (o_slave_select_oe_n)
  );

  assign o_reg_rdata         = st_ff.rdata;
  assign o_reg_ack           = st_ff.ack;
  assign o_irq               = st_ff.irq;
  assign o_tx_dma_req        = st_ff.tx_req;
  assign o_rx_dma_req        = st_ff.rx_req;
  assign o_rx_not_empty_flag = st_ff.rxne;
  assign o_rx_fifo_level     = st_ff.lvl_code;
  assign o_tx_dma_odd_count  = st_ff.tx_odd_eff;
  assign o_rx_dma_odd_count  = st_ff.rx_odd_eff;
  assign o_frame_bits        = st_ff.frame_bits;
  assign o_fifo_byte_access  = st_ff.byte_access;
  assign o_packed_mode       = st_ff.packed_mode;

  // alternate format reaches only the select generator, through the link crossing
  logic unused_rst;
  assign unused_rst = ^rst_val;

endmodule : sct_ctl_second

//--- sct_params.svh
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH

`define SCT_ADDR_W        8
`define SCT_CTL1_OFF      8'h04
`define SCT_RST_BASIC     32'h0000_0000
`define SCT_RST_FIFO      32'h0000_0700
`define SCT_MASK_BASIC    32'h0000_00ff
`define SCT_MASK_FIFO     32'h0000_7fff
`define SCT_MASK_ODD      32'h0000_6000
`define SCT_B_TXODD       14
`define SCT_B_RXODD       13
`define SCT_B_BYTE        12
`define SCT_DZ_HI         11
`define SCT_DZ_LO         8
`define SCT_B_TXIE        7
`define SCT_B_RXIE        6
`define SCT_B_ERROR_IRQ_EN       5
`define SCT_B_ALT         4
`define SCT_B_PULSE       3
`define SCT_B_DRV         2
`define SCT_B_TXDMA       1
`define SCT_B_RXDMA       0
`define SCT_DZ_MIN        4'h3
`define SCT_DZ_FORCE      4'h7
`define SCT_DZ_BYTE_MAX   4'h7
`define SCT_LVL_ONE       3'h1
`define SCT_LVL_TWO       3'h2
`define SCT_CODE_EMPTY    2'h0
`define SCT_CODE_QUARTER  2'h1
`define SCT_CODE_HALF     2'h2
`define SCT_CODE_FULL     2'h3
`define SCT_CFG_W         5
`define SCT_CFG_ALT       0
`define SCT_CFG_PULSE     1
`define SCT_CFG_DRV       2
`define SCT_CFG_MST       3
`define SCT_CFG_EN        4

`endif

//--- sct_pkg.sv
`include "sct_params.svh"

package sct_pkg;

  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] rdata;
    logic        ack;
    logic        irq;
    logic        tx_req;
    logic        rx_req;
    logic        rxne;
    logic [1:0]  lvl_code;
    logic        tx_odd_eff;
    logic        rx_odd_eff;
    logic [4:0]  frame_bits;
    logic        byte_access;
    logic        packed_mode;
  } sct_main_t;

  typedef struct packed {
    logic [`SCT_CFG_W-1:0] data;
    logic                  req_tgl;
    logic                  busy;
    logic [1:0]            ack_sync;
    logic                  ack_seen;
  } sct_cdc_src_t;

  typedef struct packed {
    logic [`SCT_CFG_W-1:0] data;
    logic [2:0]            req_sync;
    logic                  ack_tgl;
  } sct_cdc_dst_t;

  typedef enum logic [1:0] {
    SCT_SEL_IDLE,
    SCT_SEL_FRAME,
    SCT_SEL_PULSE
  } sct_sel_state_t;

  typedef struct packed {
    sct_sel_state_t state;
    logic           ss_out;
    logic           ss_oe_n;
  } sct_sel_t;

endpackage : sct_pkg

//--- sct_cfg_cdc.sv
`include "sct_params.svh"

// handshake crossing for the quasi-static link configuration word
module sct_cfg_cdc (
  // source side
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [`SCT_CFG_W-1:0] i_cfg,
  // link side
  input  wire logic                  i_link_clk,
  output logic      [`SCT_CFG_W-1:0] o_cfg
);

  sct_pkg::sct_cdc_src_t src_ff;
  sct_pkg::sct_cdc_src_t nxt_src;
  sct_pkg::sct_cdc_dst_t dst_ff;
  sct_pkg::sct_cdc_dst_t nxt_dst;

  // data is held stable while busy, so the link side samples a settled word
  always_comb
  begin
    nxt_src = src_ff;
    nxt_src.ack_sync = {src_ff.ack_sync[0], dst_ff.ack_tgl};
    nxt_src.ack_seen = src_ff.ack_sync[1];
    if (src_ff.busy)
    begin
      if (src_ff.ack_sync[1] == src_ff.req_tgl)
      begin
        nxt_src.busy = 1'b0;
      end
    end
    else if (i_cfg != src_ff.data)
    begin
      nxt_src.data    = i_cfg;
      nxt_src.req_tgl = ~src_ff.req_tgl;
      nxt_src.busy    = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      src_ff <= '0;
    end
    else
    begin
      src_ff <= nxt_src;
    end
  end

  always_comb
  begin
    nxt_dst = dst_ff;
    nxt_dst.req_sync = {dst_ff.req_sync[1:0], src_ff.req_tgl};
    if (dst_ff.req_sync[2] != dst_ff.req_sync[1])
    begin
      nxt_dst.data    = src_ff.data;
      nxt_dst.ack_tgl = dst_ff.req_sync[1];
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dst_ff <= '0;
    end
    else
    begin
      dst_ff <= nxt_dst;
    end
  end

  assign o_cfg = dst_ff.data;

endmodule : sct_cfg_cdc

//--- sct_sel_gen.sv
`include "sct_params.svh"

// slave-select pin driver, runs on the link clock
module sct_sel_gen (
  // clock and reset
  input  wire logic                  i_link_clk,
  input  wire logic                  i_rst_n,
  // configuration and framing
  input  wire logic [`SCT_CFG_W-1:0] i_cfg,
  input  wire logic                  i_frame_start,
  input  wire logic                  i_frame_end,
  // pin
  output logic                       o_ss_out,
  output logic                       o_ss_oe_n
);

  sct_pkg::sct_sel_t sel_ff;
  sct_pkg::sct_sel_t nxt_sel;
  logic              pulse_ok;

  // pulsing only in standard framing; the alternate format frames itself
  assign pulse_ok = i_cfg[`SCT_CFG_PULSE] & ~i_cfg[`SCT_CFG_ALT];

  always_comb
  begin
    nxt_sel = sel_ff;
    nxt_sel.ss_oe_n = ~(i_cfg[`SCT_CFG_DRV] & i_cfg[`SCT_CFG_MST] &
                        i_cfg[`SCT_CFG_EN]);
    case (sel_ff.state)
      sct_pkg::SCT_SEL_IDLE:
      begin
        nxt_sel.ss_out = 1'b1;
        if (i_frame_start && i_cfg[`SCT_CFG_EN])
        begin
          nxt_sel.state  = sct_pkg::SCT_SEL_FRAME;
          nxt_sel.ss_out = 1'b0;
        end
      end
      sct_pkg::SCT_SEL_FRAME:
      begin
        nxt_sel.ss_out = 1'b0;
        // frame_start low means the far side left the frame; release the pin
        if (!i_cfg[`SCT_CFG_EN] || !i_frame_start)
        begin
          nxt_sel.state  = sct_pkg::SCT_SEL_IDLE;
          nxt_sel.ss_out = 1'b1;
        end
        else if (i_frame_end && pulse_ok)
        begin
          nxt_sel.state  = sct_pkg::SCT_SEL_PULSE;
          nxt_sel.ss_out = 1'b1;
        end
      end
      sct_pkg::SCT_SEL_PULSE:
      begin
        nxt_sel.state  = sct_pkg::SCT_SEL_FRAME;
        nxt_sel.ss_out = 1'b0;
        if (!i_cfg[`SCT_CFG_EN] || !i_frame_start)
        begin
          nxt_sel.state  = sct_pkg::SCT_SEL_IDLE;
          nxt_sel.ss_out = 1'b1;
        end
      end
      default:
      begin
        nxt_sel.state  = sct_pkg::SCT_SEL_IDLE;
        nxt_sel.ss_out = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_ff <= '{state: sct_pkg::SCT_SEL_IDLE, ss_out: 1'b1, ss_oe_n: 1'b1};
    end
    else
    begin
      sel_ff <= nxt_sel;
    end
  end

  assign o_ss_out  = sel_ff.ss_out;
  assign o_ss_oe_n = sel_ff.ss_oe_n;

endmodule : sct_sel_gen

//--- sct_ctl_second_checker.sv
module sct_ctl_second_checker #(
  parameter bit HAS_FIFO = 1'b1
) (
  // ref domain
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_reg_sel,
  input wire logic        i_reg_wr,
  input wire logic        i_unit_enable,
  input wire logic        i_data_wr_half,
  input wire logic        i_tx_empty_flag,
  input wire logic [2:0]  i_rx_fifo_bytes,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        o_reg_ack,
  input wire logic        o_tx_dma_req,
  input wire logic        o_rx_dma_req,
  input wire logic        o_rx_not_empty_flag,
  input wire logic [1:0]  o_rx_fifo_level,
  input wire logic        o_tx_dma_odd_count,
  input wire logic        o_rx_dma_odd_count,
  input wire logic [4:0]  o_frame_bits,
  input wire logic        o_fifo_byte_access,
  input wire logic        o_packed_mode,
  // link domain
  input wire logic        i_link_clk,
  input wire logic        i_link_frame_start,
  input wire logic        o_slave_select_out
);
  sequence take_s;
    i_reg_sel && !o_reg_ack;
  endsequence
  sequence frame_idle_s;
    !i_link_frame_start;
  endsequence

  ack_after_take_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    take_s |=> o_reg_ack) else $error("ack missing after request");
  reserved_read_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_reg_ack && !$past(i_reg_wr) |-> o_reg_rdata[31:15] == 17'h0) else $error("reserved bits set");
  rx_flag_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_rx_not_empty_flag == ($past(i_rx_fifo_bytes) >=
      ((HAS_FIFO && !o_fifo_byte_access) ? 3'h2 : 3'h1))) else $error("rx flag threshold");
  rx_level_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_rx_fifo_level == (($past(i_rx_fifo_bytes) > 3'h2) ? 2'h3 : $past(i_rx_fifo_bytes[1:0])))
    else $error("rx level code");
  rx_dma_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_rx_dma_req |-> o_rx_not_empty_flag && $past(i_unit_enable)) else $error("rx request");
  tx_dma_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_tx_dma_req |-> $past(i_tx_empty_flag && i_unit_enable)) else $error("tx request");
  packed_need_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_packed_mode |-> $past(i_data_wr_half) && o_frame_bits <= 5'd8) else $error("packed mode");
  odd_need_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_tx_dma_odd_count || o_rx_dma_odd_count |-> o_packed_mode) else $error("odd count");
  frame_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_frame_bits inside {[5'd4:5'd16]} && (HAS_FIFO || o_frame_bits == 5'd8))
    else $error("frame bits");
  select_idle_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    frame_idle_s ##1 frame_idle_s |-> o_slave_select_out) else $error("select not idle");
endmodule : sct_ctl_second_checker

bind sct_ctl_second sct_ctl_second_checker #(.HAS_FIFO(HAS_FIFO)) u_chk (.*);

//--- sct_link_partner.sv
// far-side framer: two back-to-back frames, counts select highs inside them
module sct_link_partner (
  // control
  input  wire logic i_link_clk,
  input  wire logic i_go,
  input  wire logic i_ss_out,
  // framing and result
  output logic      o_frame_start = 1'b0,
  output logic      o_frame_end   = 1'b0,
  output logic      o_done        = 1'b0,
  output logic [3:0] o_hi_cnt     = 4'h0
);
  logic [4:0] cnt  = 5'h0;
  logic       prev = 1'b0;

  always @(posedge i_link_clk)
  begin
    prev <= o_frame_start;
    if (!i_go)
    begin
      {cnt, o_done, o_frame_start, o_frame_end, o_hi_cnt} <= '0;
    end
    else if (!o_done)
    begin
      cnt <= cnt + 5'h1;
      o_frame_start <= (cnt != 5'd17);
      o_frame_end <= (cnt == 5'd8) || (cnt == 5'd16);
      o_done <= (cnt == 5'd17);
      // first frame cycle still shows idle high, so it is skipped
      if (prev && o_frame_start && i_ss_out)
        o_hi_cnt <= o_hi_cnt + 4'h1;
    end
  end
endmodule : sct_link_partner

//--- sct_ctl_second_tb.sv
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module sct_ctl_second_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, ack, irq;
  logic       unit_en = 1'b0, master = 1'b0, half = 1'b0, tx_empty = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [3:0] be = 4'h0, hi_cnt;
  logic [2:0] bytes = 3'h0;
  logic [4:0] errs = 5'h0, fbits;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic       txr, rxr, rxne, txodd, rxodd, byte_acc, pk, fs, fe, ss, ss_oe_n, p_done;
  logic [1:0] lvl;
  int         tests_run = 0;
  int         n_errors = 0;

  initial forever #5 clk = ~clk;
  initial #3.3 forever #6 lclk = ~lclk;

  sct_ctl_second #(.HAS_FIFO(1'b1)) DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_sel(sel), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_be(be), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_unit_enable(unit_en), .i_master_mode(master), .i_data_wr_half(half),
    .i_tx_empty_flag(tx_empty), .i_rx_fifo_bytes(bytes), .i_crc_mismatch_flag(errs[0]),
    .i_config_fault_flag(errs[1]), .i_format_error_flag(errs[2]),
    .i_rx_overrun_flag(errs[3]), .i_tx_underrun_flag(errs[4]), .o_irq(irq),
    .o_tx_dma_req(txr), .o_rx_dma_req(rxr), .o_rx_not_empty_flag(rxne),
    .o_rx_fifo_level(lvl), .o_tx_dma_odd_count(txodd), .o_rx_dma_odd_count(rxodd),
    .o_frame_bits(fbits), .o_fifo_byte_access(byte_acc), .o_packed_mode(pk),
    .i_link_clk(lclk), .i_link_frame_start(fs), .i_link_frame_end(fe),
    .o_slave_select_out(ss), .o_slave_select_oe_n(ss_oe_n));

  sct_link_partner u_far (.i_link_clk(lclk), .i_go(go), .i_ss_out(ss), .o_frame_start(fs),
    .o_frame_end(fe), .o_done(p_done), .o_hi_cnt(hi_cnt));

  task automatic complete_run();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic timeout();
    n_errors++;
    $display("CHECK FAILED t=%0t wait expired", $time);
    complete_run();
  endtask : timeout

  // sel dropped at the ack edge, otherwise the request is taken again
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
    int i;
    @(posedge clk);
    {sel, wr, addr, be, wdata} <= {1'b1, w, a, b, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    q = rdata;
    sel <= 1'b0;
    if (i == 20)
      timeout();
  endtask : xfer

  task automatic wr_ctl(input logic [31:0] d);
    xfer(1'b1, 8'h04, 4'h3, d);
  endtask : wr_ctl

  task automatic chk_ctl(input logic [31:0] e);
    xfer(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, e)
  endtask : chk_ctl

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask : settle

  task automatic wait_oe(input logic v);
    int i;
    for (i = 0; i < 100 && ss_oe_n !== v; i++)
      @(posedge clk);
    `CHK(ss_oe_n, v)
  endtask : wait_oe

  task automatic frames(input logic [3:0] e);
    int i;
    go <= 1'b1;
    for (i = 0; i < 200 && p_done !== 1'b1; i++)
      @(posedge clk);
    if (i == 200)
      timeout();
    `CHK(hi_cnt, e)
    go <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : frames

  task automatic t_basic();
    chk_ctl(32'h0000_0700);
    `CHK({fbits, lvl, ss_oe_n}, {5'd8, 2'h0, 1'b1})
    xfer(1'b1, 8'h08, 4'hf, 32'h0000_00ff);
    xfer(1'b0, 8'h08, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    chk_ctl(32'h0000_0700);
    for (int c = 0; c < 16; c++)
    begin
      xfer(1'b1, 8'h04, 4'h2, {16'hffff, 4'h0, 4'(c), 8'hff});
      chk_ctl({20'h0, (c < 3) ? 4'h7 : 4'(c), 8'h00});
      `CHK(fbits, (c < 3) ? 5'd8 : 5'(c + 1))
    end
    $display("test basic done");
  endtask : t_basic

  task automatic t_odd();
    unit_en <= 1'b1;
    wr_ctl(32'h6703);
    chk_ctl(32'h0703);
    unit_en <= 1'b0;
    wr_ctl(32'h6703);
    chk_ctl(32'h6703);
    half <= 1'b1;
    settle();
    `CHK({pk, txodd, rxodd}, 3'h7)
    wr_ctl(32'h6702);
    settle();
    `CHK({txodd, rxodd}, 2'h2)
    wr_ctl(32'h6803);
    settle();
    `CHK({pk, txodd, rxodd}, 3'h0)
    half <= 1'b0;
    wr_ctl(32'hffff_ffff);
    chk_ctl(32'h0000_7fff);
    $display("test odd done");
  endtask : t_odd

  task automatic t_rx();
    unit_en <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      wr_ctl({19'h0, 1'(m), 12'h701});
      for (int n = 0; n < 5; n++)
      begin
        bytes <= 3'(n);
        settle();
        `CHK(lvl, (n > 2) ? 2'h3 : 2'(n))
        `CHK({byte_acc, rxne}, {1'(m), 1'(n >= 2 - m)})
        `CHK(rxr, 1'(n >= 2 - m))
      end
    end
    wr_ctl(32'h0700);
    settle();
    `CHK(rxr, 1'b0)
    bytes <= 3'h0;
    $display("test rx done");
  endtask : t_rx

  task automatic t_irq();
    tx_empty <= 1'b1;
    wr_ctl(32'h0780);
    settle();
    `CHK({irq, txr}, 2'h2)
    wr_ctl(32'h0702);
    settle();
    `CHK({irq, txr}, 2'h1)
    tx_empty <= 1'b0;
    wr_ctl(32'h0740);
    bytes <= 3'h2;
    settle();
    `CHK({irq, txr}, 2'h2)
    bytes <= 3'h0;
    wr_ctl(32'h0720);
    for (int e = 0; e < 5; e++)
    begin
      errs <= 5'(1 << e);
      settle();
      `CHK(irq, 1'b1)
    end
    errs <= 5'h0;
    settle();
    `CHK(irq, 1'b0)
    $display("test irq done");
  endtask : t_irq

  task automatic t_link();
    master <= 1'b1;
    wr_ctl(32'h070c);
    wait_oe(1'b0);
    frames(4'h1);
    wr_ctl(32'h071c);
    // no visible sign of the crossing here, so allow a generous margin
    repeat (40) @(posedge clk);
    frames(4'h0);
    `CHK(ss, 1'b1)
    wr_ctl(32'h0700);
    wait_oe(1'b1);
    $display("test link done");
  endtask : t_link

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_odd();
    t_rx();
    t_irq();
    t_link();
    complete_run();
  end
endmodule : sct_ctl_second_tb
